// [src/owld_map.svh]
// Address map, field positions, reset values and defaults of the loader.
`ifndef OWLD_MAP_SVH
`define OWLD_MAP_SVH

// Register and flash word byte addresses.
`define OWLD_ADDR_USER 32'h1fff0080
`define OWLD_ADDR_PROT 32'h1fff0084
`define OWLD_ADDR_BOOT 32'h1fff0088
`define OWLD_ADDR_CTRL 32'h1fff00a0
`define OWLD_ADDR_STAT 32'h1fff00a4
`define OWLD_ADDR_MASK 32'h1fff00a8

// Reset contents of the internal option registers.
`define OWLD_RST_USER 32'h0155beaa
`define OWLD_RST_PROT 32'hf4ff0b00
`define OWLD_RST_BOOT 32'hffff0000

// Field positions in the true half of each word.
`define OWLD_WDT_STOP 15
`define OWLD_RST_PIN 14
`define OWLD_DBG_PIN 13
`define OWLD_WDT_SW 12
`define OWLD_LEV_HI 11
`define OWLD_LEV_LO 9
`define OWLD_BOR_ON 8
`define OWLD_LAST_HI 11
`define OWLD_LAST_LO 8
`define OWLD_FIRST_HI 3
`define OWLD_FIRST_LO 0
`define OWLD_BOOT_HI 15
`define OWLD_BOOT_LO 14
`define OWLD_SIZE_HI 2
`define OWLD_SIZE_LO 0

// Safe values written when a field fails its complement check.
`define OWLD_DEF_LEV 3'h0
`define OWLD_DEF_FIRST 4'h0
`define OWLD_DEF_LAST 4'hb
`define OWLD_DEF_SIZE 3'h0

// Brown-out thresholds in tenths of a volt.
`define OWLD_RISE_BASE 6'h12
`define OWLD_FALL_BASE 6'h11

// Protected area step is 2 KB; loader area ends below this address.
`define OWLD_PROT_SHIFT 11
`define OWLD_KB_SHIFT 10
`define OWLD_LDR_TOP 32'h08006000
`define OWLD_LDR_MAX_KB 3'h4

// Control and status bit positions.
`define OWLD_CTRL_RELOAD 0
`define OWLD_STAT_VERR 0
`define OWLD_STAT_DONE 1
`define OWLD_STAT_W 2

`endif

// [src/owld_pkg.sv]
// Types shared by the option word loader and its users.
package owld_pkg;

	typedef enum logic [1:0] {
		LD_FETCH = 2'b00,
		LD_WAIT = 2'b01,
		LD_IDLE = 2'b10
	} owld_state_e;

	typedef enum logic [1:0] {
		BOOT_MAIN = 2'b00,
		BOOT_LOADER = 2'b01,
		BOOT_SRAM = 2'b10
	} owld_boot_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} owld_bus_s;

	typedef struct packed {
		logic wdt_stop_run;
		logic wdt_soft_select;
		logic pin_c0_reset;
		logic pin_c0_gpio;
		logic pin_c0_debug;
		logic pin_b6_debug;
		logic pin_b6_gpio;
		logic brownout_on;
		logic [2:0] brownout_level;
		logic [5:0] bor_rise_dv;
		logic [5:0] bor_fall_dv;
		logic [15:0] prot_first_off;
		logic [15:0] prot_last_off;
		owld_boot_e boot_src;
		logic [2:0] loader_kb;
		logic [31:0] loader_base;
	} owld_cfg_s;

endpackage

// [src/owld_loader.sv]
// Option word loader: fetches, checks and decodes the option words.
// Notes on behaviour
// - On reset release or a reload request the three words are fetched.
// - The stop bit freezes the watchdog in stop mode at 0, runs it at 1.
// - The two pin bits assign reset, debug and general use to two pins.
// - The level field picks a threshold pair from 1.8/1.7V in 0.2V steps.
// - The enable bit turns the detector on and gates the level field.
// - The last field gives the protected area end in 2 KB steps.
// - The first field gives the protected area start in 2 KB steps.
// - The protected word carries complements of both fields for checking.
// - The boot word carries complements of its three fields.
// - The two boot bits pick main flash, the loader area or SRAM.
// - The size field reserves 0 to 4 KB ending at the top of the area.
// - Factory contents of the protected and boot words are fixed values.
// - A failed check sets the verify error and loads safe defaults.
`timescale 1ns/10ps
`include "owld_map.svh"

module owld_loader
	import owld_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input owld_bus_s bus_req,
	output logic [31:0] bus_rdata_q,
	output logic flash_rd_q,
	output logic [31:0] flash_addr_q,
	input wire logic [31:0] flash_rdata,
	input wire logic flash_ack,
	output logic sys_hold_q,
	output owld_cfg_s cfg_q,
	output logic irq_q
);

	// True when every masked bit of a field equals the inverse of its copy.
	function automatic logic owld_ok(input logic [3:0] t, input logic [3:0] c,
		input logic [3:0] m);
		owld_ok = (((t ^ c) & m) == m);
	endfunction

	owld_state_e st_q, st_d;
	logic [1:0] idx_q, idx_d;
	logic flash_rd_d, sys_hold_d;
	logic [31:0] flash_addr_d;
	logic [31:0] user_q, user_d, prot_q, prot_d, boot_q, boot_d;
	logic verr_ev, done_ev, reload;
	logic [15:0] tv, cv;
	logic [7:0] uf;
	logic [3:0] pf, pl;
	logic [2:0] bs;
	logic bh, bl, ok_all;
	owld_cfg_s cfg_d;
	logic [`OWLD_STAT_W-1:0] stat_q, stat_d, mask_q, mask_d, set_ev, clr;
	logic irq_d;
	logic [31:0] bus_rdata_d;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// A write of one to the reload bit restarts the whole load.
	assign reload = bus_req.wr && bus_req.addr == `OWLD_ADDR_CTRL
		&& bus_req.wdata[`OWLD_CTRL_RELOAD];

	// Loader sequence: fetch each word, check it and store the result.
	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		flash_rd_d = 1'b0;
		flash_addr_d = flash_addr_q;
		sys_hold_d = sys_hold_q;
		user_d = user_q;
		prot_d = prot_q;
		boot_d = boot_q;
		verr_ev = 1'b0;
		done_ev = 1'b0;
		tv = flash_rdata[15:0];
		cv = flash_rdata[31:16];
		uf = 8'h00;
		pf = 4'h0;
		pl = 4'h0;
		bs = 3'h0;
		bh = 1'b0;
		bl = 1'b0;
		ok_all = 1'b1;
		case (st_q)
			LD_FETCH:
			begin
				flash_rd_d = 1'b1;
				case (idx_q)
					2'h0: flash_addr_d = `OWLD_ADDR_USER;
					2'h1: flash_addr_d = `OWLD_ADDR_PROT;
					default: flash_addr_d = `OWLD_ADDR_BOOT;
				endcase
				st_d = LD_WAIT;
			end
			LD_WAIT:
			begin
				if (flash_ack)
				begin
					case (idx_q)
						2'h0:
						begin
							// Each user field is checked alone; failures use defaults.
							uf[7] = owld_ok({3'h0, tv[`OWLD_WDT_STOP]},
								{3'h0, cv[`OWLD_WDT_STOP]}, 4'h1)
								? tv[`OWLD_WDT_STOP] : 1'b1;
							uf[6] = owld_ok({3'h0, tv[`OWLD_RST_PIN]},
								{3'h0, cv[`OWLD_RST_PIN]}, 4'h1)
								? tv[`OWLD_RST_PIN] : 1'b0;
							uf[5] = owld_ok({3'h0, tv[`OWLD_DBG_PIN]},
								{3'h0, cv[`OWLD_DBG_PIN]}, 4'h1)
								? tv[`OWLD_DBG_PIN] : 1'b1;
							uf[4] = owld_ok({3'h0, tv[`OWLD_WDT_SW]},
								{3'h0, cv[`OWLD_WDT_SW]}, 4'h1)
								? tv[`OWLD_WDT_SW] : 1'b1;
							uf[3:1] = owld_ok({1'b0, tv[`OWLD_LEV_HI:`OWLD_LEV_LO]},
								{1'b0, cv[`OWLD_LEV_HI:`OWLD_LEV_LO]}, 4'h7)
								? tv[`OWLD_LEV_HI:`OWLD_LEV_LO]
								: `OWLD_DEF_LEV;
							uf[0] = owld_ok({3'h0, tv[`OWLD_BOR_ON]},
								{3'h0, cv[`OWLD_BOR_ON]}, 4'h1)
								? tv[`OWLD_BOR_ON] : 1'b0;
							ok_all = (tv[15:8] == ~cv[15:8]);
							user_d = {~uf, 8'h00, uf, 8'h00};
						end
						2'h1:
						begin
							// The protected area is kept or replaced as a whole.
							ok_all = owld_ok(tv[`OWLD_LAST_HI:`OWLD_LAST_LO],
								cv[`OWLD_LAST_HI:`OWLD_LAST_LO], 4'hf)
								&& owld_ok(tv[`OWLD_FIRST_HI:`OWLD_FIRST_LO],
								cv[`OWLD_FIRST_HI:`OWLD_FIRST_LO], 4'hf);
							pl = ok_all ? tv[`OWLD_LAST_HI:`OWLD_LAST_LO]
								: `OWLD_DEF_LAST;
							pf = ok_all ? tv[`OWLD_FIRST_HI:`OWLD_FIRST_LO]
								: `OWLD_DEF_FIRST;
							prot_d = {4'h0, ~pl, 4'h0, ~pf, 4'h0, pl, 4'h0, pf};
						end
						default:
						begin
							// Boot fields are checked one by one against their copies.
							bh = owld_ok({3'h0, tv[`OWLD_BOOT_HI]},
								{3'h0, cv[`OWLD_BOOT_HI]}, 4'h1)
								? tv[`OWLD_BOOT_HI] : 1'b0;
							bl = owld_ok({3'h0, tv[`OWLD_BOOT_LO]},
								{3'h0, cv[`OWLD_BOOT_LO]}, 4'h1)
								? tv[`OWLD_BOOT_LO] : 1'b0;
							bs = owld_ok({1'b0, tv[`OWLD_SIZE_HI:`OWLD_SIZE_LO]},
								{1'b0, cv[`OWLD_SIZE_HI:`OWLD_SIZE_LO]}, 4'h7)
								? tv[`OWLD_SIZE_HI:`OWLD_SIZE_LO]
								: `OWLD_DEF_SIZE;
							ok_all = (tv[15:14] == ~cv[15:14])
								&& (tv[2:0] == ~cv[2:0]);
							boot_d = {~bh, ~bl, 11'h000, ~bs, bh, bl, 11'h000, bs};
						end
					endcase
					verr_ev = !ok_all;
					if (idx_q == 2'h2)
					begin
						st_d = LD_IDLE;
						sys_hold_d = 1'b0;
						done_ev = 1'b1;
					end
					else
					begin
						idx_d = idx_q + 2'h1;
						st_d = LD_FETCH;
					end
				end
			end
			LD_IDLE:
			begin
				st_d = LD_IDLE;
			end
			default:
			begin
				st_d = LD_FETCH;
				idx_d = 2'h0;
			end
		endcase
		// A reload request restarts from the first word and holds the system.
		// A word that arrives in the same cycle is dropped with its events.
		if (reload)
		begin
			st_d = LD_FETCH;
			idx_d = 2'h0;
			sys_hold_d = 1'b1;
			flash_rd_d = 1'b0;
			user_d = user_q;
			prot_d = prot_q;
			boot_d = boot_q;
			verr_ev = 1'b0;
			done_ev = 1'b0;
		end
	end

	// Loader registers; the factory contents stand until the first load.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= LD_FETCH;
			idx_q <= 2'h0;
			flash_rd_q <= 1'b0;
			flash_addr_q <= 32'h00000000;
			sys_hold_q <= 1'b1;
			user_q <= `OWLD_RST_USER;
			prot_q <= `OWLD_RST_PROT;
			boot_q <= `OWLD_RST_BOOT;
		end
		else
		begin
			st_q <= st_d;
			idx_q <= idx_d;
			flash_rd_q <= flash_rd_d;
			flash_addr_q <= flash_addr_d;
			sys_hold_q <= sys_hold_d;
			user_q <= user_d;
			prot_q <= prot_d;
			boot_q <= boot_d;
		end
	end

	// Decode the stored words into the system settings.
	always_comb
	begin
		cfg_d = '0;
		cfg_d.wdt_stop_run = user_q[`OWLD_WDT_STOP];
		cfg_d.wdt_soft_select = user_q[`OWLD_WDT_SW];
		cfg_d.pin_c0_reset = !user_q[`OWLD_RST_PIN];
		cfg_d.pin_c0_gpio = user_q[`OWLD_RST_PIN] && !user_q[`OWLD_DBG_PIN];
		cfg_d.pin_c0_debug = user_q[`OWLD_RST_PIN] && user_q[`OWLD_DBG_PIN];
		cfg_d.pin_b6_debug = !cfg_d.pin_c0_debug;
		cfg_d.pin_b6_gpio = cfg_d.pin_c0_debug;
		cfg_d.brownout_on = user_q[`OWLD_BOR_ON];
		if (cfg_d.brownout_on)
		begin
			cfg_d.brownout_level = user_q[`OWLD_LEV_HI:`OWLD_LEV_LO];
			cfg_d.bor_rise_dv = `OWLD_RISE_BASE
				+ {2'h0, cfg_d.brownout_level, 1'b0};
			cfg_d.bor_fall_dv = `OWLD_FALL_BASE
				+ {2'h0, cfg_d.brownout_level, 1'b0};
		end
		cfg_d.prot_first_off = 16'(prot_q[`OWLD_FIRST_HI:`OWLD_FIRST_LO])
			<< `OWLD_PROT_SHIFT;
		cfg_d.prot_last_off = 16'(prot_q[`OWLD_LAST_HI:`OWLD_LAST_LO])
			<< `OWLD_PROT_SHIFT;
		if (!boot_q[`OWLD_BOOT_LO])
			cfg_d.boot_src = BOOT_MAIN;
		else if (boot_q[`OWLD_BOOT_HI])
			cfg_d.boot_src = BOOT_LOADER;
		else
			cfg_d.boot_src = BOOT_SRAM;
		cfg_d.loader_kb = boot_q[`OWLD_SIZE_HI] ? `OWLD_LDR_MAX_KB
			: boot_q[`OWLD_SIZE_HI:`OWLD_SIZE_LO];
		cfg_d.loader_base = `OWLD_LDR_TOP
			- (32'(cfg_d.loader_kb) << `OWLD_KB_SHIFT);
	end

	// Decoded settings register.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_q <= '0;
		else
			cfg_q <= cfg_d;
	end

	// Sticky status: a new event wins over a write-one clear.
	assign set_ev = {done_ev, verr_ev};
	genvar gi;
	generate
		for (gi = 0; gi < `OWLD_STAT_W; gi = gi + 1)
		begin : g_stat
			assign clr[gi] = bus_req.wr && bus_req.addr == `OWLD_ADDR_STAT
				&& bus_req.wdata[gi];
			assign stat_d[gi] = set_ev[gi] || (stat_q[gi] && !clr[gi]);
		end
	endgenerate

	// Mask write, interrupt level and read data for one cycle.
	always_comb
	begin
		mask_d = mask_q;
		if (bus_req.wr && bus_req.addr == `OWLD_ADDR_MASK)
			mask_d = bus_req.wdata[`OWLD_STAT_W-1:0];
		irq_d = |(stat_d & mask_d);
		bus_rdata_d = 32'h00000000;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				`OWLD_ADDR_USER: bus_rdata_d = user_q;
				`OWLD_ADDR_PROT: bus_rdata_d = prot_q;
				`OWLD_ADDR_BOOT: bus_rdata_d = boot_q;
				`OWLD_ADDR_STAT: bus_rdata_d = 32'(stat_q);
				`OWLD_ADDR_MASK: bus_rdata_d = 32'(mask_q);
				default: bus_rdata_d = 32'h00000000;
			endcase
		end
	end

	// Register bus and interrupt registers.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
			bus_rdata_q <= 32'h00000000;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			bus_rdata_q <= bus_rdata_d;
		end
	end

	// A reload request holds the system and fetches the user word next.
	property p_reload_fetch;
		reload |=> sys_hold_q ##1 (flash_rd_q
			&& flash_addr_q == `OWLD_ADDR_USER);
	endproperty
	a_reload_fetch: assert property (p_reload_fetch)
		else $error("reload did not fetch the user word");

	// A checked stop bit reaches the decoded settings two cycles later.
	property p_stop_bit;
		(st_q == LD_WAIT && flash_ack && idx_q == 2'h0 && !reload
			&& flash_rdata[15] != flash_rdata[31])
			|=> ##1 cfg_q.wdt_stop_run == $past(flash_rdata[15], 2);
	endproperty
	a_stop_bit: assert property (p_stop_bit)
		else $error("watchdog stop setting does not follow the word");

	// A cleared reset-pin bit makes pin_c0 the reset input.
	property p_pins;
		!user_q[`OWLD_RST_PIN] |=> cfg_q.pin_c0_reset
			&& cfg_q.pin_b6_debug && !cfg_q.pin_c0_debug;
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin assignment wrong for reset pattern");

	// Top brown-out code gives 3.2V rising and 3.1V falling.
	property p_bor_top;
		(user_q[`OWLD_BOR_ON] && user_q[11:9] == 3'h7)
			|=> cfg_q.bor_rise_dv == 6'h20 && cfg_q.bor_fall_dv == 6'h1f;
	endproperty
	a_bor_top: assert property (p_bor_top)
		else $error("brown-out thresholds wrong for top code");

	// With the detector off no level is applied.
	property p_bor_off;
		!user_q[`OWLD_BOR_ON] |=> cfg_q.brownout_level == 3'h0
			&& !cfg_q.brownout_on;
	endproperty
	a_bor_off: assert property (p_bor_off)
		else $error("brown-out level active while detector is off");

	// A protected word that fails its check flags and covers all flash.
	property p_prot_bad;
		(st_q == LD_WAIT && flash_ack && idx_q == 2'h1 && !reload
			&& flash_rdata[3:0] != ~flash_rdata[19:16])
			|=> stat_q[`OWLD_STAT_VERR] && prot_q[11:8] == 4'hb
			&& prot_q[3:0] == 4'h0;
	endproperty
	a_prot_bad: assert property (p_prot_bad)
		else $error("failed protected word not replaced by defaults");

	// Protected start offset is the field times 2 KB.
	property p_prot_first;
		prot_q[3:0] == 4'h2 |=> cfg_q.prot_first_off == 16'h1000;
	endproperty
	a_prot_first: assert property (p_prot_first)
		else $error("protected start offset wrong");

	// A cleared low boot bit always starts from main flash.
	property p_boot_main;
		!boot_q[`OWLD_BOOT_LO] |=> cfg_q.boot_src == BOOT_MAIN;
	endproperty
	a_boot_main: assert property (p_boot_main)
		else $error("boot source not main flash for pattern x0");

	// Any size code with the top bit set reserves 4 KB.
	property p_loader_max;
		boot_q[`OWLD_SIZE_HI] |=> cfg_q.loader_base == 32'h08005000;
	endproperty
	a_loader_max: assert property (p_loader_max)
		else $error("loader area base wrong for 4 KB code");

endmodule

// [test/owld_flash_model.sv]
// Flash information memory model that answers the loader's word reads.
`timescale 1ns/10ps

module owld_flash_model
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic rd,
	input wire logic [31:0] addr,
	input wire logic [31:0] word_user,
	input wire logic [31:0] word_prot,
	input wire logic [31:0] word_boot,
	input wire logic [1:0] lat,
	output logic ack,
	output logic [31:0] rdata
);
	logic pend;
	logic [1:0] cnt;
	logic [31:0] sel;

	// Picks the option word at the held address; other words read as ones.
	always_comb
	begin
		case (addr[3:2])
			2'h0: sel = word_user;
			2'h1: sel = word_prot;
			2'h2: sel = word_boot;
			default: sel = 32'hffffffff;
		endcase
	end

	// Answers each read after the set latency; the data toggles otherwise.
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pend <= 1'b0;
			cnt <= 2'h0;
			ack <= 1'b0;
			rdata <= 32'h0;
		end
		else
		begin
			ack <= 1'b0;
			rdata <= ~rdata;
			if (rd)
			begin
				pend <= 1'b1;
				cnt <= lat;
			end
			else if (pend && cnt <= 2'h1)
			begin
				ack <= 1'b1;
				rdata <= sel;
				pend <= 1'b0;
			end
			else if (pend)
				cnt <= cnt - 2'h1;
		end
	end
endmodule

// [test/owld_loader_tb_top.sv]
// Self-checking bench for the option word loader.
`timescale 1ns/10ps
`include "owld_map.svh"

module owld_loader_tb_top
	import owld_pkg::*;
();
	logic clock;
	logic sys_rst;
	owld_bus_s bus_req;
	logic [31:0] bus_rdata_q;
	logic flash_rd_q;
	logic [31:0] flash_addr_q;
	logic [31:0] flash_rdata;
	logic flash_ack;
	logic sys_hold_q;
	owld_cfg_s cfg_q;
	logic irq_q;
	logic [31:0] w_user;
	logic [31:0] w_prot;
	logic [31:0] w_boot;
	logic [1:0] lat;
	logic [31:0] rv;
	logic [7:0] b;
	logic [2:0] ib;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	owld_loader u_owld_loader (.clock(clock), .sys_rst(sys_rst),
		.bus_req(bus_req), .bus_rdata_q(bus_rdata_q),
		.flash_rd_q(flash_rd_q), .flash_addr_q(flash_addr_q),
		.flash_rdata(flash_rdata), .flash_ack(flash_ack),
		.sys_hold_q(sys_hold_q), .cfg_q(cfg_q), .irq_q(irq_q));

	owld_flash_model u_owld_flash_model (.clock(clock), .sys_rst(sys_rst),
		.rd(flash_rd_q), .addr(flash_addr_q), .word_user(w_user),
		.word_prot(w_prot), .word_boot(w_boot), .lat(lat),
		.ack(flash_ack), .rdata(flash_rdata));

	// Builds stored words with reserved bits clear and complements set.
	function automatic logic [31:0] mk_user(input logic [7:0] v);
		return {~v, 8'h00, v, 8'h00};
	endfunction
	function automatic logic [31:0] mk_prot(input logic [3:0] l,
		input logic [3:0] f);
		return {4'h0, ~l, 4'h0, ~f, 4'h0, l, 4'h0, f};
	endfunction
	function automatic logic [31:0] mk_boot(input logic h, input logic o,
		input logic [2:0] s);
		return {~h, ~o, 11'h000, ~s, h, o, 11'h000, s};
	endfunction

	// Works out the decoded settings from the raw field values.
	function automatic owld_cfg_s exp_cfg(input logic [7:0] v,
		input logic [3:0] l, input logic [3:0] f, input logic h,
		input logic o, input logic [2:0] s);
		owld_cfg_s c;
		logic [2:0] lv;
		lv = v[0] ? v[3:1] : 3'h0;
		c.wdt_stop_run = v[7];
		c.wdt_soft_select = v[4];
		c.pin_c0_reset = ~v[6];
		c.pin_c0_gpio = v[6] & ~v[5];
		c.pin_c0_debug = v[6] & v[5];
		c.pin_b6_debug = ~(v[6] & v[5]);
		c.pin_b6_gpio = v[6] & v[5];
		c.brownout_on = v[0];
		c.brownout_level = lv;
		c.bor_rise_dv = v[0] ? 6'h12 + {2'h0, lv, 1'b0} : 6'h00;
		c.bor_fall_dv = v[0] ? 6'h11 + {2'h0, lv, 1'b0} : 6'h00;
		c.prot_first_off = {1'b0, f, 11'h000};
		c.prot_last_off = {1'b0, l, 11'h000};
		c.boot_src = !o ? BOOT_MAIN : (h ? BOOT_LOADER : BOOT_SRAM);
		c.loader_kb = s[2] ? 3'h4 : s;
		c.loader_base = 32'h08006000 - {19'h0, c.loader_kb, 10'h000};
		return c;
	endfunction

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_cfg(input owld_cfg_s got, input owld_cfg_s exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata_q;
	endtask

	// Waits for the load to finish, then one edge for the decode to land.
	task automatic wait_load();
		int n;
		n = 0;
		while (sys_hold_q !== 1'b0 && n < 200)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 200)
			num_errors++;
		@(posedge clock);
		#1;
	endtask

	task automatic reload();
		bus_wr(`OWLD_ADDR_CTRL, 32'h00000001);
		#1;
		chk32({31'h0, sys_hold_q}, 32'h1);
		wait_load();
	endtask

	task automatic irq_is(input logic e);
		@(posedge clock);
		#1;
		chk32({31'h0, irq_q}, {31'h0, e});
	endtask

	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Makes the 20 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Cuts a hung run short.
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	// Main sequence of tests.
	initial
	begin
		sys_rst = 1'b1;
		bus_req = '0;
		w_user = mk_user(8'hbe);
		w_prot = 32'hf4ff0b00;
		w_boot = 32'hffff0000;
		lat = 2'h3;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		bus_rd(`OWLD_ADDR_PROT, rv);
		chk32(rv, 32'hf4ff0b00);
		bus_rd(`OWLD_ADDR_BOOT, rv);
		chk32(rv, 32'hffff0000);
		wait_load();
		chk_cfg(cfg_q,
			exp_cfg(8'hbe, 4'hb, 4'h0, 1'b0, 1'b0, 3'h0));
		$display("test factory done, errors %0d", num_errors);

		bus_rd(32'h1fff00b0, rv);
		chk32(rv, 32'h0);
		bus_wr(32'h1fff00b0, 32'hffffffff);
		bus_rd(`OWLD_ADDR_CTRL, rv);
		chk32(rv, 32'h0);
		bus_wr(`OWLD_ADDR_MASK, 32'h00000002);
		irq_is(1'b1);
		bus_wr(`OWLD_ADDR_STAT, 32'h00000000);
		irq_is(1'b1);
		bus_wr(`OWLD_ADDR_STAT, 32'h00000002);
		irq_is(1'b0);
		bus_rd(`OWLD_ADDR_MASK, rv);
		chk32(rv, 32'h2);
		$display("test bus done, errors %0d", num_errors);

		for (int i = 0; i < 8; i++)
		begin
			ib = i[2:0];
			b = {ib[0], ib[1], ib[2], ~ib[0], ib, (i != 5)};
			w_user <= mk_user(b);
			w_prot <= mk_prot({1'b1, ib}, {ib, 1'b0});
			w_boot <= mk_boot(ib[0], ib[1], ib);
			lat <= ib[1:0];
			reload();
			chk_cfg(cfg_q,
				exp_cfg(b, {1'b1, ib}, {ib, 1'b0},
				ib[0], ib[1], ib));
			bus_rd(`OWLD_ADDR_USER, rv);
			chk32(rv, mk_user(b));
			bus_rd(`OWLD_ADDR_PROT, rv);
			chk32(rv, mk_prot({1'b1, ib}, {ib, 1'b0}));
			bus_rd(`OWLD_ADDR_BOOT, rv);
			chk32(rv, mk_boot(ib[0], ib[1], ib));
		end
		$display("test decode done, errors %0d", num_errors);

		bus_wr(`OWLD_ADDR_MASK, 32'h00000001);
		w_user <= mk_user(8'hf3) ^ 32'h40000000;
		w_prot <= mk_prot(4'h9, 4'h2) ^ 32'h00010000;
		w_boot <= mk_boot(1'b1, 1'b1, 3'h2) ^ 32'h80000000;
		reload();
		chk_cfg(cfg_q,
			exp_cfg(8'hb3, 4'hb, 4'h0, 1'b0, 1'b1, 3'h2));
		bus_rd(`OWLD_ADDR_USER, rv);
		chk32(rv, mk_user(8'hb3));
		bus_rd(`OWLD_ADDR_STAT, rv);
		chk32(rv, 32'h3);
		chk32({31'h0, irq_q}, 32'h1);
		bus_wr(`OWLD_ADDR_STAT, 32'h00000001);
		irq_is(1'b0);
		bus_rd(`OWLD_ADDR_STAT, rv);
		chk32(rv, 32'h2);
		$display("test verify done, errors %0d", num_errors);
		print_verdict();
	end
endmodule
